// ===== logic/scg_fault_check.sv
/*
 * Fault checker for peripheral accesses: flags any access aimed at a unit
 * whose clock is gated off, one cycle after the access.
 * Assumes one-hot unit select and synchronous inputs.
 */
`timescale 1ns/100ps
module scg_fault_check
   import scg_pkg::*;
(
   // clock and reset
   input wire logic sys_clk,
   input wire logic rst_n,
   // access and gate state
   input wire scg_periph_req_s periph_req,
   input wire logic [SCG_UNITS-1:0] unit_clk_en,
   // fault report
   output logic bus_fault,
   output logic [SCG_UNITS-1:0] fault_unit
);

   logic next_bus_fault;
   logic [SCG_UNITS-1:0] next_fault_unit;

   // ----------------------------------------------------------------
   // fault decode
   // ----------------------------------------------------------------
   // fault on gated access
   always_comb begin
      next_fault_unit = periph_req.sel & ~unit_clk_en;
      next_bus_fault = (periph_req.read | periph_req.write) & (|next_fault_unit);
      if (!(periph_req.read | periph_req.write)) begin
         next_fault_unit = '0;
      end
   end

   // registered so the fault is a clean pulse, one cycle after the access and as long as the access
   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         bus_fault <= 1'b0;
         fault_unit <= '0;
      end else begin
         bus_fault <= next_bus_fault;
         fault_unit <= next_fault_unit;
      end
   end

endmodule // scg_fault_check

// ===== logic/scg_pkg.sv
/*
 * Package for the sleep-mode clock gating register block: register map,
 * field positions, reset values, bus record types and rate codes.
 * Assumes a single 40 MHz system clock and an Avalon-MM register port.
 */
package scg_pkg;

   // ----------------------------------------------------------------
   // register map
   // ----------------------------------------------------------------
   localparam logic [11:0] SCG_OFS_SLEEP_GATE = 12'h110;
   localparam logic [11:0] SCG_OFS_MODE_CTRL = 12'h200;
   localparam logic [11:0] SCG_OFS_STATUS = 12'h204;
   localparam logic [11:0] SCG_OFS_FAULT = 12'h208;

   // ----------------------------------------------------------------
   // sleep gate register fields
   // ----------------------------------------------------------------
   localparam int SCG_BIT_CONV = 16;
   localparam int SCG_BIT_RATE_LO = 8;
   localparam int SCG_BIT_HIB = 6;
   localparam int SCG_BIT_WDT = 3;
   localparam logic [31:0] SCG_GATE_RESET = 32'h0000_0040;
   localparam logic [31:0] SCG_GATE_WMASK = 32'h0001_0348;

   // mode control fields
   localparam int SCG_BIT_SLEEP = 0;
   localparam int SCG_BIT_AUTO = 1;
   localparam logic [31:0] SCG_MODE_RESET = 32'h0000_0000;
   localparam logic [31:0] SCG_MODE_WMASK = 32'h0000_0003;
   localparam logic [31:0] SCG_UNMAPPED_DATA = 32'h0000_0000;

   // converter sample rate codes
   localparam logic [1:0] SCG_RATE_125K = 2'h0;
   localparam logic [1:0] SCG_RATE_250K = 2'h1;
   localparam logic [1:0] SCG_RATE_500K = 2'h2;

   // unit indices for gate vectors
   localparam int SCG_UNIT_CONV = 2;
   localparam int SCG_UNIT_HIB = 1;
   localparam int SCG_UNIT_WDT = 0;
   localparam int SCG_UNITS = 3;

   // ----------------------------------------------------------------
   // types
   // ----------------------------------------------------------------
   typedef struct packed {
      logic read;
      logic write;
      logic [11:0] address;
      logic [31:0] writedata;
      logic [3:0] byteenable;
   } scg_av_req_s;

   typedef struct packed {
      logic [SCG_UNITS-1:0] sel;
      logic read;
      logic write;
   } scg_periph_req_s;

endpackage

// ===== logic/scg_sleep_gate.sv
/*
 * Sleep-mode clock gating register 0 with Avalon-MM slave, per-unit clock
 * enables, converter rate select and gated-access fault reporting.
 * Assumes the clock enables feed integrated clock gates outside this block
 * and that the system supplies a sleep indication and run-mode enables.
 */
// Notes on behaviour
// - a unit gets its clock while its gate bit is one and is held off while it is zero.
// - any read or write aimed at a unit whose clock is off raises a bus fault.
// - after reset the register reads 0x00000040, only the hibernation gate set.
// - the gate bits apply only in sleep and only when auto clock gating is enabled; the rate code applies at all times.
// - bit 16 gates the converter clock, read/write, reset zero.
// - bits 9:8 pick converter rate 125K, 250K or 500K samples per second, reset zero.
// - bit 6 gates the hibernation clock, read/write, reset one.
// - bit 3 gates the watchdog clock, read/write, reset zero.
// - reserved bits read zero and ignore writes; software preserves them.
`timescale 1ns/100ps
module scg_sleep_gate
   import scg_pkg::*;
(
   // clock and reset
   input wire logic sys_clk,
   input wire logic rst_n,
   // avalon-mm slave
   input wire logic avs_read,
   input wire logic avs_write,
   input wire logic [11:0] avs_address,
   input wire logic [31:0] avs_writedata,
   input wire logic [3:0] avs_byteenable,
   output logic [31:0] avs_readdata,
   output logic avs_waitrequest,
   output logic [1:0] avs_response,
   // system state
   input wire logic sys_sleep,
   input wire logic [SCG_UNITS-1:0] run_clk_en,
   // peripheral access monitor
   input wire logic [SCG_UNITS-1:0] periph_sel,
   input wire logic periph_read,
   input wire logic periph_write,
   // unit controls
   output logic [SCG_UNITS-1:0] unit_clk_en,
   output logic [1:0] converter_sample_rate_sel,
   output logic bus_fault,
   output logic [SCG_UNITS-1:0] fault_unit
);

   // ----------------------------------------------------------------
   // declarations
   // ----------------------------------------------------------------
   typedef enum logic [1:0] {SCG_IDLE, SCG_ANSWER} scg_bus_e;

   scg_bus_e state;
   scg_bus_e next_state;
   logic [31:0] sleep_clock_gate_0;
   logic [31:0] next_sleep_clock_gate_0;
   logic [31:0] mode_ctrl;
   logic [31:0] next_mode_ctrl;
   logic [31:0] fault_log;
   logic [31:0] next_fault_log;
   logic [31:0] next_readdata;
   logic [1:0] next_response;
   logic next_waitrequest;
   logic [SCG_UNITS-1:0] next_unit_clk_en;
   logic [SCG_UNITS-1:0] sleep_en;
   logic sleep_active;
   logic fault_pulse;
   logic [SCG_UNITS-1:0] fault_vec;
   scg_av_req_s req;
   scg_periph_req_s preq;

   // bundle the bus and peripheral requests
   assign req = '{read: avs_read, write: avs_write, address: avs_address,
                  writedata: avs_writedata, byteenable: avs_byteenable};
   assign preq = '{sel: periph_sel, read: periph_read, write: periph_write};

   // ----------------------------------------------------------------
   // helper functions
   // ----------------------------------------------------------------
   // merge byte-enabled write data under a writable mask
   function automatic logic [31:0] scg_merge(input logic [31:0] old_val,
                                             input logic [31:0] wdata,
                                             input logic [3:0] be,
                                             input logic [31:0] wmask);
      logic [31:0] lane;
      lane = {{8{be[3]}}, {8{be[2]}}, {8{be[1]}}, {8{be[0]}}};
      scg_merge = (old_val & ~(lane & wmask)) | (wdata & lane & wmask);
   endfunction

   // gate vector from a gating register image
   function automatic logic [SCG_UNITS-1:0] scg_units(input logic [31:0] reg_val);
      logic [SCG_UNITS-1:0] v;
      v = '0;
      v[SCG_UNIT_CONV] = reg_val[SCG_BIT_CONV];
      v[SCG_UNIT_HIB] = reg_val[SCG_BIT_HIB];
      v[SCG_UNIT_WDT] = reg_val[SCG_BIT_WDT];
      scg_units = v;
   endfunction

   // ----------------------------------------------------------------
   // bus slave and registers
   // ----------------------------------------------------------------
   // one wait cycle per access keeps read data registered
   always_comb begin
      next_state = state;
      next_sleep_clock_gate_0 = sleep_clock_gate_0;
      next_mode_ctrl = mode_ctrl;
      next_fault_log = fault_log;
      next_readdata = avs_readdata;
      next_response = avs_response;
      next_waitrequest = 1'b1;
      case (state)
         SCG_IDLE: begin
            if (req.read || req.write) begin
               next_state = SCG_ANSWER;
               next_waitrequest = 1'b0;
               next_response = 2'h0;
               next_readdata = SCG_UNMAPPED_DATA;
               case (req.address)
                  SCG_OFS_SLEEP_GATE: begin
                     if (req.write) begin
                        next_sleep_clock_gate_0 = scg_merge(sleep_clock_gate_0,
                           req.writedata, req.byteenable, SCG_GATE_WMASK);
                     end
                     next_readdata = sleep_clock_gate_0;
                  end
                  SCG_OFS_MODE_CTRL: begin
                     if (req.write) begin
                        next_mode_ctrl = scg_merge(mode_ctrl, req.writedata,
                           req.byteenable, SCG_MODE_WMASK);
                     end
                     next_readdata = mode_ctrl;
                  end
                  SCG_OFS_STATUS: begin
                     next_readdata = {29'h0, unit_clk_en};
                  end
                  SCG_OFS_FAULT: begin
                     // write one to clear, a new fault wins
                     if (req.write) begin
                        next_fault_log = fault_log & ~(req.writedata & {29'h0, 3'h7});
                     end
                     next_readdata = fault_log;
                  end
                  default: begin
                     next_response = 2'h2; // slave error, reads zero
                  end
               endcase
            end
         end
         SCG_ANSWER: begin
            next_state = SCG_IDLE;
         end
         default: begin
            next_state = SCG_IDLE;
         end
      endcase
      if (fault_pulse) begin
         next_fault_log = next_fault_log | {29'h0, fault_vec};
      end
   end

   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         state <= SCG_IDLE;
         sleep_clock_gate_0 <= SCG_GATE_RESET;
         mode_ctrl <= SCG_MODE_RESET;
         fault_log <= 32'h0000_0000;
         avs_readdata <= 32'h0000_0000;
         avs_response <= 2'h0;
         avs_waitrequest <= 1'b1;
      end else begin
         state <= next_state;
         sleep_clock_gate_0 <= next_sleep_clock_gate_0;
         mode_ctrl <= next_mode_ctrl;
         fault_log <= next_fault_log;
         avs_readdata <= next_readdata;
         avs_response <= next_response;
         avs_waitrequest <= next_waitrequest;
      end
   end

   // ----------------------------------------------------------------
   // clock enables and rate
   // ----------------------------------------------------------------
   // sleep with auto gating
   assign sleep_active = (sys_sleep | mode_ctrl[SCG_BIT_SLEEP]) & mode_ctrl[SCG_BIT_AUTO];
   assign sleep_en = scg_units(sleep_clock_gate_0);

   always_comb begin
      next_unit_clk_en = run_clk_en;
      if (sleep_active) begin
         next_unit_clk_en = sleep_en;
      end
   end

   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         unit_clk_en <= 3'h2; // hibernation only, matching the reset image
         converter_sample_rate_sel <= SCG_RATE_125K;
      end else begin
         unit_clk_en <= next_unit_clk_en;
         converter_sample_rate_sel <= sleep_clock_gate_0[SCG_BIT_RATE_LO+:2];
      end
   end

   // ----------------------------------------------------------------
   // gated access faults
   // ----------------------------------------------------------------
   // fault checker
   scg_fault_check u_fault (
      .sys_clk(sys_clk),
      .rst_n(rst_n),
      .periph_req(preq),
      .unit_clk_en(unit_clk_en),
      .bus_fault(fault_pulse),
      .fault_unit(fault_vec)
   );

   assign bus_fault = fault_pulse;
   assign fault_unit = fault_vec;

endmodule // scg_sleep_gate

// ===== test/scg_sleep_gate_bench.sv
/*
 * Testbench for the sleep gate block: register access, gating in and out
 * of sleep, rate codes, faults and a mid-run reset.
 * Assumes the package and the block are compiled before it.
 */
`timescale 1ns/100ps
module scg_sleep_gate_bench
   import scg_pkg::*;
;
   logic sys_clk = 1'b0;
   logic rst_n, avs_read, avs_write, avs_waitrequest, sys_sleep, bus_fault;
   logic periph_read, periph_write;
   logic [11:0] avs_address;
   logic [31:0] avs_writedata, avs_readdata, rdat;
   logic [3:0] avs_byteenable;
   logic [1:0] avs_response, converter_sample_rate_sel, rsp;
   logic [2:0] run_clk_en, periph_sel, unit_clk_en, fault_unit;
   int fail_count, n_compared;
   scg_sleep_gate uut (.sys_clk, .rst_n, .avs_read, .avs_write, .avs_address, .avs_writedata,
      .avs_byteenable, .avs_readdata, .avs_waitrequest, .avs_response, .sys_sleep, .run_clk_en,
      .periph_sel, .periph_read, .periph_write, .unit_clk_en, .converter_sample_rate_sel,
      .bus_fault, .fault_unit);
   // 40 MHz clock
   always #12.5 sys_clk = ~sys_clk;
   // ----------------------------------------------------------------
   // tasks
   // ----------------------------------------------------------------
   task automatic check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
      n_compared++;
      if (seen !== exp) begin
         $display("FAIL %s expected %h seen %h", nm, exp, seen);
         fail_count++;
      end
   endtask
   // request held until waitrequest is sampled low at a rising edge; a hang is
   // left to the watchdog
   task automatic bus(input logic rd, input logic [11:0] a, input logic [31:0] wd,
      input logic [3:0] be);
      @(posedge sys_clk);
      avs_read <= rd;
      avs_write <= !rd;
      avs_address <= a;
      avs_writedata <= wd;
      avs_byteenable <= be;
      do begin
         @(posedge sys_clk);
      end while (avs_waitrequest !== 1'b0);
      // answer taken at the same edge that ends the request
      rdat = avs_readdata;
      rsp = avs_response;
      avs_read <= 1'b0;
      avs_write <= 1'b0;
   endtask
   task automatic rchk(input logic [11:0] a, input logic [31:0] exp, input logic [1:0] er);
      bus(1'b1, a, 32'h0000_0000, 4'hF);
      check($sformatf("read %h", a), rdat, exp);
      check("response", {30'h0, rsp}, {30'h0, er});
   endtask
   // enables settle one edge after an input change; checked after two
   task automatic en_chk(input logic [2:0] exp);
      repeat (2) @(posedge sys_clk);
      @(negedge sys_clk);
      check("unit_clk_en", {29'h0, unit_clk_en}, {29'h0, exp});
      // end on a rising edge so the caller's next input change lands there
      @(posedge sys_clk);
   endtask
   task automatic acc(input logic [2:0] sel, input logic wr, input logic [2:0] exp);
      @(posedge sys_clk);
      periph_sel <= sel;
      periph_read <= !wr;
      periph_write <= wr;
      @(posedge sys_clk);
      periph_read <= 1'b0;
      periph_write <= 1'b0;
      @(negedge sys_clk);
      check("bus_fault", {31'h0, bus_fault}, {31'h0, |exp});
      if (|exp) check("fault_unit", {29'h0, fault_unit}, {29'h0, exp});
   endtask
   task automatic print_verdict();
      $display("compared %0d mismatches %0d", n_compared, fail_count);
      if (fail_count == 0 && n_compared > 0) $display("ALL CHECKS OK");
      else $display("CHECKS NOT OK");
      $finish;
   endtask
   // ----------------------------------------------------------------
   // tests
   // ----------------------------------------------------------------
   initial begin
      {rst_n, avs_read, avs_write, sys_sleep, periph_read, periph_write} = '0;
      {avs_address, avs_writedata, avs_byteenable, run_clk_en, periph_sel} = '0;
      fail_count = 0;
      n_compared = 0;
      repeat (6) @(posedge sys_clk);
      rst_n <= 1'b1;
      rchk(SCG_OFS_SLEEP_GATE, SCG_GATE_RESET, 2'h0);
      // all ones except rate code 3, which software never programs
      bus(1'b0, SCG_OFS_SLEEP_GATE, 32'hFFFF_FEFF, 4'hF);
      rchk(SCG_OFS_SLEEP_GATE, 32'h0001_0248, 2'h0);
      // only the defined rate codes are used
      for (int r = 0; r < 3; r++) begin
         bus(1'b0, SCG_OFS_SLEEP_GATE, 32'h0000_0040 | (r << 8), 4'hF);
         @(negedge sys_clk);
         check("rate", {30'h0, converter_sample_rate_sel}, r);
      end
      // only lane 2 written: the converter gate alone changes
      bus(1'b0, SCG_OFS_SLEEP_GATE, 32'hFFFF_FFFF, 4'h4);
      rchk(SCG_OFS_SLEEP_GATE, 32'h0001_0240, 2'h0);
      bus(1'b0, SCG_OFS_SLEEP_GATE, 32'h0001_0008, 4'hF);
      run_clk_en <= 3'b010;
      en_chk(3'b010);
      sys_sleep <= 1'b1;
      en_chk(3'b010);
      bus(1'b0, SCG_OFS_MODE_CTRL, 32'h0000_0002, 4'hF);
      en_chk(3'b101);
      rchk(SCG_OFS_STATUS, 32'h0000_0005, 2'h0);
      acc(3'b010, 1'b0, 3'b010);
      acc(3'b001, 1'b1, 3'b000);
      acc(3'b100, 1'b0, 3'b000);
      rchk(SCG_OFS_FAULT, 32'h0000_0002, 2'h0);
      bus(1'b0, SCG_OFS_FAULT, 32'h0000_0002, 4'hF);
      rchk(SCG_OFS_FAULT, 32'h0000_0000, 2'h0);
      bus(1'b0, SCG_OFS_SLEEP_GATE, 32'h0000_0040, 4'hF);
      en_chk(3'b010);
      sys_sleep <= 1'b0;
      en_chk(3'b010);
      bus(1'b0, SCG_OFS_MODE_CTRL, 32'h0000_0003, 4'hF);
      en_chk(3'b010);
      acc(3'b001, 1'b0, 3'b001);
      rchk(12'h300, 32'h0000_0000, 2'h2);
      bus(1'b0, 12'h300, 32'hFFFF_FFFF, 4'hF);
      check("write response", {30'h0, rsp}, 32'h0000_0002);
      // reset in mid-run restores the defaults
      @(posedge sys_clk);
      rst_n <= 1'b0;
      @(posedge sys_clk);
      rst_n <= 1'b1;
      rchk(SCG_OFS_SLEEP_GATE, SCG_GATE_RESET, 2'h0);
      rchk(SCG_OFS_MODE_CTRL, SCG_MODE_RESET, 2'h0);
      print_verdict();
   end
   // watchdog well beyond the hundred or so cycles the tests need
   initial begin
      repeat (5000) @(posedge sys_clk);
      fail_count++;
      print_verdict();
   end
endmodule // scg_sleep_gate_bench
bind scg_sleep_gate scg_sleep_gate_monitor chk (.sys_clk, .rst_n, .avs_read, .avs_write,
   .avs_address, .avs_readdata, .avs_waitrequest, .avs_response, .sys_sleep, .run_clk_en,
   .periph_sel, .periph_read, .periph_write, .unit_clk_en, .bus_fault, .fault_unit);

// ===== test/scg_sleep_gate_monitor.sv
/*
 * Checker for the sleep gate block: bus handshake, responses, reserved
 * bits, clock enable stability and gated-access faults.
 * Assumes it is bound to the block's top module ports.
 */
`timescale 1ns/100ps
module scg_sleep_gate_monitor
   import scg_pkg::*;
(
   // clock and reset
   input wire logic sys_clk,
   input wire logic rst_n,
   // register bus
   input wire logic avs_read,
   input wire logic avs_write,
   input wire logic [11:0] avs_address,
   input wire logic [31:0] avs_readdata,
   input wire logic avs_waitrequest,
   input wire logic [1:0] avs_response,
   // system and peripheral side
   input wire logic sys_sleep,
   input wire logic [SCG_UNITS-1:0] run_clk_en,
   input wire logic [SCG_UNITS-1:0] periph_sel,
   input wire logic periph_read,
   input wire logic periph_write,
   input wire logic [SCG_UNITS-1:0] unit_clk_en,
   input wire logic bus_fault,
   input wire logic [SCG_UNITS-1:0] fault_unit
);
   default clocking cb @(posedge sys_clk); endclocking
   default disable iff (!rst_n);
   logic [SCG_UNITS-1:0] exp_fault;
   logic [SCG_UNITS-1:0] next_exp_fault;
   logic mapped;
   // ----------------------------------------------------------------
   // helper logic
   // ----------------------------------------------------------------
   // units hit by this cycle's access, judged against current enables
   always_comb begin
      next_exp_fault = (periph_read | periph_write) ? (periph_sel & ~unit_clk_en) : '0;
   end
   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         exp_fault <= '0;
      end else begin
         exp_fault <= next_exp_fault;
      end
   end
   assign mapped = avs_address inside {SCG_OFS_SLEEP_GATE, SCG_OFS_MODE_CTRL,
      SCG_OFS_STATUS, SCG_OFS_FAULT};
   // ----------------------------------------------------------------
   // assertions
   // ----------------------------------------------------------------
   wait_one_a: assert property (
      (avs_read | avs_write) && avs_waitrequest |=> !avs_waitrequest)
      else $error("answer not one cycle after request");
   wait_high_a: assert property (
      !avs_waitrequest |=> avs_waitrequest) else $error("waitrequest low two cycles");
   fault_raise_a: assert property (
      bus_fault == (|exp_fault)) else $error("bus fault does not match gated access");
   fault_unit_a: assert property (
      bus_fault |-> fault_unit == exp_fault) else $error("wrong faulting unit");
   resp_ok_a: assert property (
      !avs_waitrequest && mapped |-> avs_response == 2'h0) else $error("mapped access refused");
   unmapped_a: assert property (
      !avs_waitrequest && !mapped |-> avs_response == 2'h2 && avs_readdata == 32'h0000_0000)
      else $error("unmapped access not refused");
   gate_rsvd_a: assert property (
      !avs_waitrequest && avs_read && avs_address == SCG_OFS_SLEEP_GATE
      |-> (avs_readdata & ~SCG_GATE_WMASK) == 32'h0000_0000) else $error("reserved bit set");
   en_hold_a: assert property (
      $past(rst_n) && avs_waitrequest && $past(avs_waitrequest) && $stable(run_clk_en)
      && $stable(sys_sleep) |=> $stable(unit_clk_en)) else $error("enable moved by itself");
endmodule // scg_sleep_gate_monitor
